// [rtl/ssid_pkg.sv]
package ssid_pkg;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_ID_IN = 8'h41;  // Latched selection ID
  localparam logic [7:0] IDX_CFG = 8'h44;    // Own ID and parity enable
  localparam logic [7:0] IDX_CTRL = 8'h45;   // Operation control
  localparam logic [7:0] IDX_STS1 = 8'h46;   // Event status one
  localparam logic [7:0] IDX_IEN1 = 8'h47;   // Interrupt enable one
  localparam logic [7:0] IDX_STS2 = 8'h48;   // Event status two
  localparam logic [7:0] IDX_IEN2 = 8'h49;   // Interrupt enable two
  localparam logic [7:0] IDX_HBR = 8'h53;    // Host/buffer reset command

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_RST = 0;       // Status one: bus reset seen
  localparam int B_ATN = 1;       // Status one: attention seen
  localparam int B_OFS = 2;       // Status one: offset error
  localparam int B_FREE = 3;      // Status one: bus free seen
  localparam int B_BPAR = 4;      // Status one: buffer parity error
  localparam int B_SPAR = 5;      // Status one: bus parity error
  localparam int B_PARLIVE = 6;   // Status one: internal parity
  localparam int B_RSTLIVE = 7;   // Status one: live reset
  localparam int B_SEL = 0;       // Status two: selected
  localparam int B_RESEL = 1;     // Status two: reselected
  localparam int B_PAREN = 3;     // Config: parity enable
  localparam int B_AUTO = 1;      // Control: auto response enable
  localparam int B_TGT = 4;       // Control: enable target
  localparam int B_INI = 5;       // Control: enable initiator
  localparam int B_HBR = 5;       // Command: host/buffer reset
  localparam int FLAG_N = 6;      // Sticky flags in status one
  localparam int STS2_N = 2;      // Status two bits owned here
  localparam int ID_MAX = 2;      // Most ID bits on selection

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // SCSI bus pins as seen, all active low
  typedef struct packed {
    logic rst_n;
    logic atn_n;
    logic sel_n;
    logic bsy_n;
    logic io_n;
    logic dbp_n;
    logic [7:0] db_n;
  } ssid_scsi_t;

  // Response machine states, Gray along idle-select-reselect
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEL = 2'b01,
    ST_RESEL = 2'b11
  } ssid_state_t;

endpackage : ssid_pkg

// [rtl/ssid_top.sv]
// Local design decision: the APB register port.
`timescale 1ns/1ps
module ssid_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ssid_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // SCSI bus pins, asynchronous
  input wire ssid_pkg::ssid_scsi_t scsi_in,
  // Busy pin drive, open drain
  output logic scsi_bsy_o,
  output logic scsi_bsy_oe,
  // Internal transfer path, same clock
  input wire logic [7:0] int_data,
  input wire logic ofs_err,
  input wire logic buf_par_err,
  input wire logic bus_byte_stb,
  // Host interrupt
  output logic host_irq_n
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  ssid_pkg::ssid_scsi_t meta_q;  // First stage, read only by second
  ssid_pkg::ssid_scsi_t pin_q;   // Stable pin levels
  logic free_q;                  // Bus free level last cycle

  // Two flops on every bus pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '1;
      pin_q <= '1;
      free_q <= 1'b1;
    end else begin
      meta_q <= scsi_in;
      pin_q <= meta_q;
      free_q <= pin_q.bsy_n & pin_q.sel_n;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [7:0] db_act;     // Data bus, active high
  logic [3:0] id_cnt;     // Asserted ID bits
  logic own_id;           // Own ID bit present
  logic par_ok;           // Odd parity over data and parity
  logic cond_base;        // Common selection conditions
  logic sel_hit;          // Selection detected
  logic resel_hit;        // Reselection detected
  logic bus_free_rise;    // Entry into bus free
  logic [7:0] cfg_q;
  logic [7:0] ctrl_q;

  assign db_act = ~pin_q.db_n;
  assign par_ok = ^{db_act, ~pin_q.dbp_n};
  assign own_id = db_act[cfg_q[2:0]];
  assign bus_free_rise = pin_q.bsy_n & pin_q.sel_n & ~free_q;

  // Count asserted ID bits
  always_comb begin
    id_cnt = 4'h0;
    for (int i = 0; i < 8; i++) begin
      id_cnt = id_cnt + {3'h0, db_act[i]};
    end
  end

  logic [1:0] st_q;

  // Conditions shared by selection and reselection
  assign cond_base = ctrl_q[ssid_pkg::B_AUTO] & ~pin_q.sel_n & pin_q.bsy_n & own_id
    & (par_ok | ~cfg_q[ssid_pkg::B_PAREN]) & pin_q.rst_n
    & (st_q == ssid_pkg::ST_IDLE);
  assign sel_hit = cond_base & pin_q.io_n
    & (id_cnt <= 4'(ssid_pkg::ID_MAX));
  assign resel_hit = cond_base & ~pin_q.io_n
    & (id_cnt == 4'(ssid_pkg::ID_MAX));

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  logic [7:0] idx;        // Word index of the access
  logic wr_en;            // Write takes effect this edge
  logic mapped;           // Address hits a register
  logic [7:0] wb;         // Write byte
  assign idx = paddr[ssid_pkg::ADDR_W-1:2];
  assign wr_en = psel & penable & pwrite & pready;
  assign wb = pwdata[7:0];

  // Address decode
  always_comb begin
    case (idx)
      ssid_pkg::IDX_ID_IN, ssid_pkg::IDX_CFG, ssid_pkg::IDX_CTRL,
      ssid_pkg::IDX_STS1, ssid_pkg::IDX_IEN1, ssid_pkg::IDX_STS2,
      ssid_pkg::IDX_IEN2, ssid_pkg::IDX_HBR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0] sts1_q, sts1_d;   // Sticky flags one
  logic [7:0] ien1_q, ien1_d;   // Enables one
  logic [1:0] sts2_q, sts2_d;   // Sticky flags two
  logic [1:0] ien2_q, ien2_d;   // Enables two
  logic [7:0] cfg_d;
  logic [7:0] ctrl_d;
  logic [7:0] id_q, id_d;       // Latched ID byte
  logic hbr_q, hbr_d;           // Host/buffer reset pulse
  logic par_q, par_d;           // Internal parity sample
  logic [5:0] ev1;              // Set events, status one
  logic wr_s1, wr_s2;

  assign wr_s1 = wr_en & (idx == ssid_pkg::IDX_STS1);
  assign wr_s2 = wr_en & (idx == ssid_pkg::IDX_STS2);

  // Event sources for status one
  always_comb begin
    ev1 = '0;
    ev1[ssid_pkg::B_ATN] = ~pin_q.atn_n;
    ev1[ssid_pkg::B_OFS] = ofs_err;
    ev1[ssid_pkg::B_FREE] = bus_free_rise;
    ev1[ssid_pkg::B_BPAR] = buf_par_err;
    ev1[ssid_pkg::B_SPAR] = bus_byte_stb & cfg_q[ssid_pkg::B_PAREN] & ~par_ok;
  end

  // Next values of all software-visible state
  always_comb begin
    sts1_d = sts1_q;
    ien1_d = ien1_q;
    sts2_d = sts2_q;
    ien2_d = ien2_q;
    cfg_d = cfg_q;
    ctrl_d = ctrl_q;
    id_d = id_q;
    hbr_d = 1'b0;
    par_d = ^int_data;
    // Software writes
    if (wr_s1) begin
      sts1_d = sts1_q & ~wb[5:0];
    end
    if (wr_s2) begin
      sts2_d = sts2_q & ~wb[1:0];
    end
    if (wr_en) begin
      case (idx)
        ssid_pkg::IDX_CFG: cfg_d = wb;
        ssid_pkg::IDX_CTRL: ctrl_d = wb;
        ssid_pkg::IDX_IEN1: ien1_d = {2'h0, wb[5:0]};
        ssid_pkg::IDX_IEN2: ien2_d = wb[1:0];
        ssid_pkg::IDX_HBR: hbr_d = wb[ssid_pkg::B_HBR];
        default: ;
      endcase
    end
    // Hardware sets win over clears
    sts1_d = sts1_d | ev1;
    if (sel_hit) begin
      sts2_d[ssid_pkg::B_SEL] = 1'b1;
      ctrl_d[ssid_pkg::B_TGT] = 1'b1;
      id_d = db_act;
    end
    if (resel_hit) begin
      sts2_d[ssid_pkg::B_RESEL] = 1'b1;
      ctrl_d[ssid_pkg::B_INI] = 1'b1;
      id_d = db_act;
    end
    // Bus reset in progress
    if (!pin_q.rst_n) begin
      sts1_d = 6'(1 << ssid_pkg::B_RST);
      sts2_d = '0;
      ctrl_d = ssid_pkg::RST_BYTE;
    end
    // Host/buffer reset command
    if (hbr_q) begin
      sts1_d = '0;
      ien1_d = ssid_pkg::RST_BYTE;
      sts2_d = '0;
      ien2_d = '0;
      ctrl_d = ssid_pkg::RST_BYTE;
    end
  end

  // Register the state, chip reset clears it all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts1_q <= '0;
      ien1_q <= ssid_pkg::RST_BYTE;
      sts2_q <= '0;
      ien2_q <= '0;
      cfg_q <= ssid_pkg::RST_BYTE;
      ctrl_q <= ssid_pkg::RST_BYTE;
      id_q <= ssid_pkg::RST_BYTE;
      hbr_q <= 1'b0;
      par_q <= 1'b0;
    end else begin
      sts1_q <= sts1_d;
      ien1_q <= ien1_d;
      sts2_q <= sts2_d;
      ien2_q <= ien2_d;
      cfg_q <= cfg_d;
      ctrl_q <= ctrl_d;
      id_q <= id_d;
      hbr_q <= hbr_d;
      par_q <= par_d;
    end
  end

  // ----------------------------------------------------------------
  // Busy response machine
  // ----------------------------------------------------------------
  ssid_pkg::ssid_state_t st_d;
  logic bsy_oe_d;

  // Hold busy after selection or reselection
  always_comb begin
    st_d = ssid_pkg::ssid_state_t'(st_q);
    case (ssid_pkg::ssid_state_t'(st_q))
      ssid_pkg::ST_IDLE: begin
        if (sel_hit) begin
          st_d = ssid_pkg::ST_SEL;
        end else if (resel_hit) begin
          st_d = ssid_pkg::ST_RESEL;
        end
      end
      ssid_pkg::ST_SEL: begin
        // Target keeps busy while enabled
        if (!ctrl_q[ssid_pkg::B_TGT]) begin
          st_d = ssid_pkg::ST_IDLE;
        end
      end
      ssid_pkg::ST_RESEL: begin
        // Release once the target lets select go
        if (pin_q.sel_n) begin
          st_d = ssid_pkg::ST_IDLE;
        end
      end
      default: st_d = ssid_pkg::ST_IDLE;
    endcase
    if (!ctrl_q[ssid_pkg::B_AUTO] || !pin_q.rst_n || hbr_q) begin
      st_d = ssid_pkg::ST_IDLE;
    end
    bsy_oe_d = (st_d != ssid_pkg::ST_IDLE);
  end

  // Register state and busy drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ssid_pkg::ST_IDLE;
      scsi_bsy_oe <= 1'b0;
    end else begin
      st_q <= st_d;
      scsi_bsy_oe <= bsy_oe_d;
    end
  end
  assign scsi_bsy_o = 1'b0;

  // ----------------------------------------------------------------
  // Read data, ready and interrupt
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;
  logic irq_d;

  // Read multiplexer
  always_comb begin
    case (idx)
      ssid_pkg::IDX_ID_IN: rd_byte = id_q;
      ssid_pkg::IDX_CFG: rd_byte = cfg_q;
      ssid_pkg::IDX_CTRL: rd_byte = ctrl_q;
      ssid_pkg::IDX_STS1: rd_byte = {~pin_q.rst_n, par_q, sts1_q};
      ssid_pkg::IDX_IEN1: rd_byte = ien1_q;
      ssid_pkg::IDX_STS2: rd_byte = {6'h00, sts2_q};
      ssid_pkg::IDX_IEN2: rd_byte = {6'h00, ien2_q};
      default: rd_byte = 8'h00;
    endcase
  end

  assign irq_d = |(sts1_d & ien1_d[5:0]) | |(sts2_d & ien2_d);

  // Answer in the first access cycle, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      host_irq_n <= 1'b1;
    end else begin
      prdata <= {24'h00_0000, rd_byte};
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      host_irq_n <= ~irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_busrst;
    !pin_q.rst_n && !hbr_q |=> sts1_q == 6'h01;
  endproperty
  a_busrst: assert property (p_busrst) else $error("bus reset flags wrong");

  property p_hbr;
    hbr_q |=> sts1_q == 6'h00 && ien1_q == 8'h00 && sts2_q == 2'h0;
  endproperty
  a_hbr: assert property (p_hbr) else $error("host reset did not clear");

  property p_w1c;
    wr_s1 && wb[ssid_pkg::B_OFS] && !ofs_err && pin_q.rst_n
      |=> !sts1_q[ssid_pkg::B_OFS];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_hold;
    sts1_q[ssid_pkg::B_RST] && !hbr_q && !(wr_s1 && wb[ssid_pkg::B_RST])
      |=> sts1_q[ssid_pkg::B_RST];
  endproperty
  a_hold: assert property (p_hold) else $error("reset flag lost");

  property p_setwins;
    wr_s1 && !pin_q.atn_n && pin_q.rst_n && !hbr_q |=> sts1_q[ssid_pkg::B_ATN];
  endproperty
  a_setwins: assert property (p_setwins) else $error("event lost on clear");

  property p_irq;
    (sts1_q & ien1_q[5:0]) != 6'h00 ##1 (sts1_q & ien1_q[5:0]) != 6'h00
      |-> !host_irq_n;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not asserted");

  property p_ien_keep;
    !pin_q.rst_n && !hbr_q && !(wr_en && idx == ssid_pkg::IDX_IEN1)
      |=> $stable(ien1_q);
  endproperty
  a_ien_keep: assert property (p_ien_keep) else $error("enable lost on bus reset");

  property p_sel;
    sel_hit && !hbr_q |=> sts2_q[ssid_pkg::B_SEL] && ctrl_q[ssid_pkg::B_TGT] && scsi_bsy_oe
      && id_q == $past(db_act);
  endproperty
  a_sel: assert property (p_sel) else $error("selection response wrong");

  property p_resel;
    resel_hit && !hbr_q |=> sts2_q[ssid_pkg::B_RESEL] && ctrl_q[ssid_pkg::B_INI] && scsi_bsy_oe;
  endproperty
  a_resel: assert property (p_resel) else $error("reselection response wrong");

  property p_abort;
    !ctrl_q[ssid_pkg::B_AUTO] |=> !scsi_bsy_oe;
  endproperty
  a_abort: assert property (p_abort) else $error("busy held after abort");

  c_sel: cover property (sel_hit ##1 scsi_bsy_oe);
  c_resel: cover property (resel_hit ##[1:20] !scsi_bsy_oe);
  c_irq: cover property (host_irq_n ##1 !host_irq_n);

endmodule : ssid_top

// [tb/ssid_bus_model.sv]
`timescale 1ns/1ps
module ssid_bus_model (
  // Levels the other bus devices put on the lines
  input wire ssid_pkg::ssid_scsi_t want,
  // Busy drive of the block, open drain
  input wire logic scsi_bsy_o,
  input wire logic scsi_bsy_oe,
  // Wired bus as the block sees it
  output ssid_pkg::ssid_scsi_t scsi_in
);
  // ----------------------------------------------------------------
  // Wired-AND bus
  // ----------------------------------------------------------------
  // Terminated lines idle high, so released lines read one; any driver pulls low
  always_comb begin
    scsi_in = want;
    // Block drives busy only while its enable is high
    if (scsi_bsy_oe) begin
      scsi_in.bsy_n = want.bsy_n & scsi_bsy_o;
    end
  end
endmodule : ssid_bus_model

// [tb/ssid_top_tb.sv]
`timescale 1ns/1ps
module ssid_top_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ssid_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic scsi_bsy_o;
  logic scsi_bsy_oe;
  logic host_irq_n;
  logic [7:0] int_data = 8'h00;
  logic ofs_err = 1'b0;
  logic buf_par_err = 1'b0;
  logic bus_byte_stb = 1'b0;
  ssid_pkg::ssid_scsi_t want = '1;  // Bus idle, all released
  ssid_pkg::ssid_scsi_t scsi_in;
  logic [32:0] exp_q[$];  // Expected {slave error, read data}
  int fail_count = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h189adb58;

  // Free-running system clock
  always #20 pclk = ~pclk;

  ssid_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scsi_in(scsi_in), .scsi_bsy_o(scsi_bsy_o),
    .scsi_bsy_oe(scsi_bsy_oe), .int_data(int_data), .ofs_err(ofs_err),
    .buf_par_err(buf_par_err), .bus_byte_stb(bus_byte_stb), .host_irq_n(host_irq_n));

  ssid_bus_model bus (.want(want), .scsi_bsy_o(scsi_bsy_o), .scsi_bsy_oe(scsi_bsy_oe),
    .scsi_in(scsi_in));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Pseudo-random source with a fixed start
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Compare and count
  task automatic check(input logic [32:0] got, input logic [32:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // One APB transfer; a gap cycle follows so psel falls between transfers
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Hold the request until pready is sampled high
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  // Note the expectation, then read; the monitor compares
  task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic err = 1'b0);
    exp_q.push_back({err, 24'h0, d});
    xfer(1'b0, idx, 8'h00);
  endtask : rd

  task automatic irq(input logic exp_n);
    check({32'h0, host_irq_n}, {32'h0, exp_n}, "host irq");
  endtask : irq

  task automatic oe(input logic exp);
    check({32'h0, scsi_bsy_oe}, {32'h0, exp}, "busy drive");
  endtask : oe

  task automatic summarize;
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Read monitor: takes the oldest note at each completed read
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) begin
        check(33'h0, 33'h1, "unexpected read");
      end else begin
        check({pslverr, prdata}, exp_q.pop_front(), "read");
      end
    end
  end

  // Watchdog against a hang
  initial begin
    tick(5000);
    fail_count++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    tick(8);
    presetn <= 1'b1;
    tick(1);
    rd(ssid_pkg::IDX_STS1, 8'h00);
    rd(ssid_pkg::IDX_IEN1, 8'h00);
    rd(ssid_pkg::IDX_STS2, 8'h00);
    rd(8'h7f, 8'h00, 1'b1);
    // Enables, reserved bits stay zero
    wr(ssid_pkg::IDX_IEN1, 8'hff);
    rd(ssid_pkg::IDX_IEN1, 8'h3f);
    irq(1'b1);
    // Attention held across a clearing write
    want.atn_n <= 1'b0;
    tick(4);
    irq(1'b0);
    wr(ssid_pkg::IDX_STS1, 8'h02);
    rd(ssid_pkg::IDX_STS1, 8'h02);
    want.atn_n <= 1'b1;
    tick(4);
    rd(ssid_pkg::IDX_STS1, 8'h02);
    wr(ssid_pkg::IDX_STS1, 8'h00);
    rd(ssid_pkg::IDX_STS1, 8'h02);
    wr(ssid_pkg::IDX_STS1, 8'h02);
    rd(ssid_pkg::IDX_STS1, 8'h00);
    irq(1'b1);
    // Offset and buffer parity pulses
    ofs_err <= 1'b1;
    tick(1);
    ofs_err <= 1'b0;
    buf_par_err <= 1'b1;
    tick(1);
    buf_par_err <= 1'b0;
    tick(1);
    rd(ssid_pkg::IDX_STS1, 8'h14);
    wr(ssid_pkg::IDX_STS1, 8'h14);
    // Bus byte with wrong parity, checking off and then on
    want.db_n <= 8'hfe;
    want.dbp_n <= 1'b0;
    tick(4);
    bus_byte_stb <= 1'b1;
    tick(1);
    bus_byte_stb <= 1'b0;
    tick(1);
    rd(ssid_pkg::IDX_STS1, 8'h00);
    wr(ssid_pkg::IDX_CFG, 8'h08);
    bus_byte_stb <= 1'b1;
    tick(1);
    bus_byte_stb <= 1'b0;
    tick(1);
    rd(ssid_pkg::IDX_STS1, 8'h20);
    wr(ssid_pkg::IDX_STS1, 8'h20);
    // Right parity leaves the flag clear
    want.dbp_n <= 1'b1;
    tick(4);
    bus_byte_stb <= 1'b1;
    tick(1);
    bus_byte_stb <= 1'b0;
    tick(1);
    rd(ssid_pkg::IDX_STS1, 8'h00);
    want.db_n <= 8'hff;
    want.dbp_n <= 1'b1;
    // Live parity of random internal data
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      int_data <= seed[7:0];
      tick(3);
      rd(ssid_pkg::IDX_STS1, {1'b0, ^seed[7:0], 6'h00});
    end
    int_data <= 8'h00;
    // Bus free after busy
    want.bsy_n <= 1'b0;
    tick(4);
    want.bsy_n <= 1'b1;
    tick(4);
    rd(ssid_pkg::IDX_STS1, 8'h08);
    wr(ssid_pkg::IDX_STS1, 8'h3f);
    // Selection of own ID 3 by ID 7
    wr(ssid_pkg::IDX_CFG, 8'h0b);
    wr(ssid_pkg::IDX_IEN2, 8'h01);
    wr(ssid_pkg::IDX_CTRL, 8'h02);
    want.sel_n <= 1'b0;
    want.db_n <= 8'h77;
    want.dbp_n <= 1'b0;
    tick(5);
    oe(1'b1);
    want.sel_n <= 1'b1;
    want.db_n <= 8'hff;
    want.dbp_n <= 1'b1;
    tick(4);
    oe(1'b1);
    irq(1'b0);
    rd(ssid_pkg::IDX_STS2, 8'h01);
    rd(ssid_pkg::IDX_CTRL, 8'h12);
    rd(ssid_pkg::IDX_ID_IN, 8'h88);
    wr(ssid_pkg::IDX_STS2, 8'h01);
    rd(ssid_pkg::IDX_STS2, 8'h00);
    irq(1'b1);
    wr(ssid_pkg::IDX_CTRL, 8'h02);
    tick(2);
    oe(1'b0);
    // Reselection with three IDs is ignored
    want.io_n <= 1'b0;
    want.sel_n <= 1'b0;
    want.db_n <= 8'h73;
    want.dbp_n <= 1'b1;
    tick(5);
    oe(1'b0);
    rd(ssid_pkg::IDX_STS2, 8'h00);
    // Reselection with two IDs
    want.db_n <= 8'h77;
    want.dbp_n <= 1'b0;
    tick(5);
    oe(1'b1);
    rd(ssid_pkg::IDX_STS2, 8'h02);
    rd(ssid_pkg::IDX_ID_IN, 8'h88);
    rd(ssid_pkg::IDX_CTRL, 8'h22);
    want.sel_n <= 1'b1;
    tick(4);
    oe(1'b0);
    wr(ssid_pkg::IDX_STS2, 8'h02);
    // Selection aborted by clearing auto response
    want.io_n <= 1'b1;
    want.sel_n <= 1'b0;
    tick(5);
    oe(1'b1);
    wr(ssid_pkg::IDX_CTRL, 8'h30);
    tick(2);
    oe(1'b0);
    want.sel_n <= 1'b1;
    want.db_n <= 8'hff;
    want.dbp_n <= 1'b1;
    tick(4);
    // Bus reset
    want.rst_n <= 1'b0;
    tick(4);
    rd(ssid_pkg::IDX_STS1, 8'h81);
    rd(ssid_pkg::IDX_STS2, 8'h00);
    rd(ssid_pkg::IDX_IEN1, 8'h3f);
    irq(1'b0);
    want.rst_n <= 1'b1;
    tick(4);
    rd(ssid_pkg::IDX_STS1, 8'h01);
    // Host/buffer reset command
    wr(ssid_pkg::IDX_HBR, 8'h20);
    tick(2);
    rd(ssid_pkg::IDX_STS1, 8'h00);
    rd(ssid_pkg::IDX_IEN1, 8'h00);
    irq(1'b1);
    summarize();
  end
endmodule : ssid_top_tb
